// >>> design/csw_top.sv
// Overview of operation
// RULE1 - Charging stops when no voltage or current limit write arrives within the watchdog period.
// RULE2 - Watchdog expiry only suspends charge; no setting held elsewhere is altered.
// RULE3 - A voltage or current limit write restarts the watchdog and resumes charge.
// RULE4 - Option bits 14:13 pick watchdog off, 44 s, 88 s or 175 s.
// RULE5 - After expiry, writing the watchdog field to off also resumes charge.
// RULE6 - High side on while error above ramp, then low side until cycle end.
// RULE7 - Every switch hand-over passes a dead time with both gates off.
// RULE8 - Low bootstrap voltage starts a refresh pulse on the low side switch.
// RULE9 - Low side switch turns off when sense voltage falls below 5 mV.
// RULE10 - Low average current or low battery holds low side off except refresh.
// RULE11 - Synchronous switching returns once average current rises above 250 mA.
// RULE12 - Input overcurrent past 4.2 ms blanking latches adapter switch off until adapter removal.
// RULE13 - Option bit 1 enables or disables input overcurrent protection.
// RULE14 - Peak overcurrent ends the high side pulse until the next cycle.
// RULE15 - Peak overcurrent threshold picked from three levels by programmed current.
// RULE16 - Battery overvoltage blocks turn-on of both switches.
// RULE17 - Battery overvoltage lasting over 30 ms disables charging completely.
// RULE18 - Discharge sink is on only during battery overvoltage.
// RULE19 - A zero voltage limit never triggers battery overvoltage.
// RULE20 - Low battery limits current, resets charge after 1 ms, resumes after 4-5 ms.
// RULE21 - Low battery caps current at 0.5 A and keeps low side off.
// RULE22 - Soft start begins at 128 mA, adds 64 mA every 240 us.
// RULE23 - Option bit 0 high inhibits charging; low permits it.
// RULE24 - Comparator inputs are synchronised; timers count prescaled ticks, except the dead time, which counts sys_clk cycles.
// RULE25 - Each fault and suspension cause is a flag gating charge enable; battery overvoltage before shutdown gates only the switches through run.
`timescale 1ns/1ps
`include "csw_consts.svh"
module csw_top
  import csw_pkg::*;
#(
  parameter int US_CYCLES = `CSW_US_CYCLES,
  parameter int US_PER_MS = `CSW_US_PER_MS,
  parameter int MS_PER_S = `CSW_MS_PER_S,
  parameter int INOC_BLANK_US = `CSW_INOC_BLANK_US,
  parameter int DEAD_CYCLES = `CSW_DEAD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pwm_clk,
  input wire logic error_amp_out,
  input wire logic bootstrap_low,
  input wire logic undercurrent_cmp,
  input wire logic avg_below_125ma,
  input wire logic avg_above_250ma,
  input wire logic battery_low,
  input wire logic input_overcurrent,
  input wire logic adapter_detect_low,
  input wire logic peak_overcurrent,
  input wire logic battery_overvoltage,
  input wire logic voltage_limit_write,
  input wire logic current_limit_write,
  input wire logic option_write,
  input wire logic [15:0] option_settings,
  input wire logic [15:0] voltage_limit,
  input wire logic [15:0] current_limit,
  input wire logic adapter_ready,
  output logic high_side_switch,
  output logic low_side_switch,
  output logic adapter_switch,
  output logic discharge_sink,
  output logic charge_active,
  output logic watchdog_expired,
  output logic input_oc_latched,
  output logic ovp_shutdown,
  output logic nonsync_mode,
  output logic [1:0] peak_ocp_level,
  output logic [15:0] current_target
);

  csw_tick_if tick_bus ();

  csw_tick_gen #(
    .US_CYCLES(US_CYCLES),
    .US_PER_MS(US_PER_MS),
    .MS_PER_S(MS_PER_S)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick(tick_bus)
  );

  csw_state_type state_ff;
  csw_state_type nxt_state;
  logic [10:0] raw_in;
  logic ovp_now;
  logic chg_ok;
  logic run;

  assign raw_in = {battery_overvoltage, peak_overcurrent, adapter_detect_low, input_overcurrent,
                   battery_low, avg_above_250ma, avg_below_125ma, undercurrent_cmp,
                   bootstrap_low, error_amp_out, pwm_clk};

  // Zero voltage limit disarms overvoltage detection
  assign ovp_now = state_ff.sync2[`CSW_IDX_OVP] && (voltage_limit != 16'h0000); // RULE16 RULE19

  // Watchdog, input overcurrent and overvoltage shutdown causes are held flags; no setting is cleared on expiry
  assign chg_ok = !option_settings[`CSW_OPT_INHIBIT_BIT] && !state_ff.wd_exp && // RULE23 RULE1 RULE2
                  !state_ff.inoc_lat && !state_ff.ovp_off && (state_ff.lowv != LOWV_WAIT) && // RULE25
                  (voltage_limit != 16'h0000) && (current_limit != 16'h0000) && adapter_ready;
  assign run = chg_ok && !ovp_now;

  function automatic logic [7:0] wd_period(input logic [1:0] sel);
    logic [7:0] p;
    case (sel)
      `CSW_WD_SEL_44: p = 8'(`CSW_WD_44_S);
      `CSW_WD_SEL_88: p = 8'(`CSW_WD_88_S);
      default: p = 8'(`CSW_WD_175_S);
    endcase
    return p;
  endfunction : wd_period

  always_comb begin
    logic cyc_start;
    logic [1:0] wd_sel;
    logic [16:0] ss_sum;
    logic [15:0] ss_next;
    cyc_start = 1'b0;
    wd_sel = option_settings[`CSW_OPT_WD_MSB:`CSW_OPT_WD_LSB];
    ss_sum = 17'h0_0000;
    ss_next = 16'h0000;
    nxt_state = state_ff;

    // Comparator outputs are asynchronous to sys_clk
    nxt_state.sync1 = raw_in; // RULE24
    nxt_state.sync2 = state_ff.sync1; // RULE24
    nxt_state.pwm_prev = state_ff.sync2[`CSW_IDX_PWM];
    cyc_start = state_ff.sync2[`CSW_IDX_PWM] && !state_ff.pwm_prev;

    // Watchdog: limit writes restart it; selecting off releases a suspension
    if (wd_sel == `CSW_WD_SEL_OFF) begin
      nxt_state.wd_cnt = 8'h00;
    end else if (tick_bus.s_tick && !state_ff.wd_exp) begin
      nxt_state.wd_cnt = state_ff.wd_cnt + 8'h01;
    end
    if ((wd_sel != `CSW_WD_SEL_OFF) && (state_ff.wd_cnt >= wd_period(wd_sel))) begin
      nxt_state.wd_exp = 1'b1; // RULE1 RULE4
    end
    if (voltage_limit_write || current_limit_write) begin
      nxt_state.wd_cnt = 8'h00; // RULE3
      nxt_state.wd_exp = 1'b0; // RULE3
    end else if (option_write && (wd_sel == `CSW_WD_SEL_OFF)) begin
      nxt_state.wd_exp = 1'b0; // RULE5
    end

    // Input overcurrent: blanking in microseconds, then latch until adapter removal
    if (option_settings[`CSW_OPT_INOC_EN_BIT] && state_ff.sync2[`CSW_IDX_INOC]) begin // RULE13
      if (tick_bus.us_tick && !state_ff.inoc_lat) begin
        nxt_state.inoc_cnt = state_ff.inoc_cnt + 13'h0001;
      end
    end else begin
      nxt_state.inoc_cnt = 13'h0000;
    end
    if (state_ff.sync2[`CSW_IDX_ADPLO]) begin
      nxt_state.inoc_lat = 1'b0; // RULE12
      nxt_state.inoc_cnt = 13'h0000;
    end
    if (state_ff.inoc_cnt >= 13'(INOC_BLANK_US)) begin
      nxt_state.inoc_lat = 1'b1; // RULE12
    end
    nxt_state.adp = !nxt_state.inoc_lat; // RULE12

    // Battery overvoltage duration; a new voltage limit re-arms charging
    if (ovp_now) begin
      if (tick_bus.ms_tick && (state_ff.ovp_cnt <= 6'(`CSW_OVP_MS))) begin
        nxt_state.ovp_cnt = state_ff.ovp_cnt + 6'h01;
      end
    end else begin
      nxt_state.ovp_cnt = 6'h00;
    end
    if (voltage_limit_write) begin
      nxt_state.ovp_off = 1'b0;
    end
    if (state_ff.ovp_cnt > 6'(`CSW_OVP_MS)) begin
      nxt_state.ovp_off = 1'b1; // RULE17
    end
    nxt_state.sink = ovp_now; // RULE18

    // Battery low: limit, reset charge after 1 ms, restart 4-5 ms later
    case (state_ff.lowv)
      LOWV_IDLE: begin
        nxt_state.lowv_cnt = 12'h000;
        if (state_ff.sync2[`CSW_IDX_BATLOW]) begin
          nxt_state.lowv = LOWV_LIMIT;
        end
      end
      LOWV_LIMIT: begin
        if (!state_ff.sync2[`CSW_IDX_BATLOW]) begin
          nxt_state.lowv = LOWV_IDLE;
        end else if (state_ff.lowv_cnt >= 12'(US_PER_MS * `CSW_LOWV_LIMIT_MS)) begin
          nxt_state.lowv = LOWV_WAIT; // RULE20
          nxt_state.lowv_cnt = 12'h000;
        end else if (tick_bus.us_tick) begin
          nxt_state.lowv_cnt = state_ff.lowv_cnt + 12'h001;
        end
      end
      LOWV_WAIT: begin
        // Counting whole ms ticks gives between four and five ms
        if (state_ff.lowv_cnt >= 12'(`CSW_LOWV_WAIT_MAX_MS)) begin
          nxt_state.lowv = LOWV_IDLE; // RULE20
        end else if (tick_bus.ms_tick) begin
          nxt_state.lowv_cnt = state_ff.lowv_cnt + 12'h001;
        end
      end
      default: begin
        nxt_state.lowv = LOWV_IDLE;
      end
    endcase

    // Non-synchronous mode has hysteresis between 125 mA and 250 mA
    if (state_ff.sync2[`CSW_IDX_AVG_LO] || state_ff.sync2[`CSW_IDX_BATLOW]) begin
      nxt_state.nonsync = 1'b1; // RULE10 RULE21
    end else if (state_ff.sync2[`CSW_IDX_AVG_HI]) begin
      nxt_state.nonsync = 1'b0; // RULE11
    end

    // Soft start ramp of the current target
    nxt_state.chg = chg_ok;
    ss_sum = {1'b0, state_ff.target} + 17'(`CSW_SS_STEP_MA);
    ss_next = (ss_sum > {1'b0, current_limit}) ? current_limit : ss_sum[15:0];
    if (!chg_ok) begin
      nxt_state.target = 16'h0000;
      nxt_state.ss_cnt = 8'h00;
    end else if (!state_ff.chg) begin
      nxt_state.target = 16'(`CSW_SS_START_MA); // RULE22
      nxt_state.ss_cnt = 8'h00;
    end else if (state_ff.target > current_limit) begin
      nxt_state.target = current_limit;
    end else if (tick_bus.us_tick) begin
      if (state_ff.ss_cnt >= 8'(`CSW_SS_STEP_US - 1)) begin
        nxt_state.ss_cnt = 8'h00;
        nxt_state.target = ss_next; // RULE22
      end else begin
        nxt_state.ss_cnt = state_ff.ss_cnt + 8'h01;
      end
    end
    if (chg_ok && state_ff.sync2[`CSW_IDX_BATLOW] && (nxt_state.target > 16'(`CSW_LOWV_CAP_MA))) begin
      nxt_state.target = 16'(`CSW_LOWV_CAP_MA); // RULE21
    end

    // Peak overcurrent threshold tracks the programmed current
    if (current_limit >= 16'(`CSW_OCP_HIGH_FROM_MA)) begin
      nxt_state.ocp_lvl = `CSW_OCP_12A; // RULE15
    end else if (current_limit >= 16'(`CSW_OCP_MID_FROM_MA)) begin
      nxt_state.ocp_lvl = `CSW_OCP_9A; // RULE15
    end else begin
      nxt_state.ocp_lvl = `CSW_OCP_6A; // RULE15
    end

    // Switch sequencer; gates follow the next state so outputs never lag it
    if (state_ff.dead_cnt != 4'h0) begin
      nxt_state.dead_cnt = state_ff.dead_cnt - 4'h1;
    end
    case (state_ff.pwm)
      PWM_IDLE: begin
        if (run && cyc_start) begin
          nxt_state.pwm = PWM_DEAD_H;
          nxt_state.dead_cnt = 4'(DEAD_CYCLES - 1);
        end
      end
      PWM_DEAD_H: begin
        if (!run) begin
          nxt_state.pwm = PWM_IDLE;
        end else if (state_ff.dead_cnt == 4'h0) begin
          nxt_state.pwm = PWM_HIGH; // RULE7
        end
      end
      PWM_HIGH: begin
        nxt_state.refresh = 1'b0;
        if (!run) begin
          nxt_state.pwm = PWM_IDLE; // RULE16
        end else if (state_ff.sync2[`CSW_IDX_PEAK] || !state_ff.sync2[`CSW_IDX_EAO] ||
                     state_ff.sync2[`CSW_IDX_BOOT]) begin
          nxt_state.pwm = PWM_DEAD_L; // RULE6 RULE14
          nxt_state.dead_cnt = 4'(DEAD_CYCLES - 1);
          nxt_state.refresh = state_ff.sync2[`CSW_IDX_BOOT]; // RULE8
        end
      end
      PWM_DEAD_L: begin
        if (!run) begin
          nxt_state.pwm = PWM_IDLE;
        end else if (state_ff.dead_cnt == 4'h0) begin
          // Refresh pulses pass even in non-synchronous mode
          if (state_ff.refresh || !state_ff.nonsync) begin // RULE10 RULE8
            nxt_state.pwm = PWM_LOW; // RULE7
          end else begin
            nxt_state.pwm = PWM_OFF;
          end
        end
      end
      PWM_LOW: begin
        if (!run) begin
          nxt_state.pwm = PWM_IDLE;
        end else if (cyc_start) begin
          nxt_state.pwm = PWM_DEAD_H; // RULE6
          nxt_state.dead_cnt = 4'(DEAD_CYCLES - 1);
        end else if (!state_ff.refresh && (state_ff.sync2[`CSW_IDX_UCP] || state_ff.nonsync)) begin
          nxt_state.pwm = PWM_OFF; // RULE9
        end
      end
      PWM_OFF: begin
        if (!run) begin
          nxt_state.pwm = PWM_IDLE;
        end else if (cyc_start) begin
          nxt_state.pwm = PWM_DEAD_H; // RULE14
          nxt_state.dead_cnt = 4'(DEAD_CYCLES - 1);
        end
      end
      default: begin
        nxt_state.pwm = PWM_IDLE;
      end
    endcase
    nxt_state.hs = (nxt_state.pwm == PWM_HIGH);
    nxt_state.ls = (nxt_state.pwm == PWM_LOW);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign high_side_switch = state_ff.hs;
  assign low_side_switch = state_ff.ls;
  assign adapter_switch = state_ff.adp;
  assign discharge_sink = state_ff.sink;
  assign charge_active = state_ff.chg;
  assign watchdog_expired = state_ff.wd_exp;
  assign input_oc_latched = state_ff.inoc_lat;
  assign ovp_shutdown = state_ff.ovp_off;
  assign nonsync_mode = state_ff.nonsync;
  assign peak_ocp_level = state_ff.ocp_lvl;
  assign current_target = state_ff.target;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_gates_not_both: assert property (!(high_side_switch && low_side_switch)) // RULE7
    else $error("Both switches on together");
  a_dead_before_high: assert property ($rose(high_side_switch) |-> !$past(low_side_switch, 1) && !$past(low_side_switch, 2)) // RULE7
    else $error("High side turned on without dead time");
  a_wd_stops_gates: assert property (watchdog_expired |=> !high_side_switch && !low_side_switch) // RULE1
    else $error("Switching continued after watchdog expiry");
  a_wd_limit_restart: assert property ((voltage_limit_write || current_limit_write) |=> !watchdog_expired) // RULE3
    else $error("Limit write did not restart watchdog");
  a_wd_off_resume: assert property ((option_write && option_settings[14:13] == 2'h0) |=> !watchdog_expired) // RULE5
    else $error("Watchdog off did not release suspension");
  a_ovp_blocks_gates: assert property (ovp_now |=> !high_side_switch && !low_side_switch) // RULE16
    else $error("Switch on during battery overvoltage");
  a_sink_with_ovp: assert property (discharge_sink |-> !high_side_switch && $past(voltage_limit) != 16'h0000) // RULE18
    else $error("Discharge sink on outside overvoltage");
  a_ovp_zero_limit: assert property (voltage_limit == 16'h0000 |=> !discharge_sink) // RULE19
    else $error("Zero voltage limit triggered overvoltage");
  a_inoc_latch_holds: assert property (input_oc_latched && !state_ff.sync2[`CSW_IDX_ADPLO] |=> input_oc_latched) // RULE12
    else $error("Input overcurrent latch released early");
  a_inoc_switch_off: assert property (input_oc_latched |-> !adapter_switch) // RULE12
    else $error("Adapter switch on while latched");
  a_inhibit_stops: assert property (option_settings[`CSW_OPT_INHIBIT_BIT] |=> !charge_active && current_target == 16'h0000) // RULE23
    else $error("Inhibit did not stop charging");
  a_peak_ends_pulse: assert property ((state_ff.pwm == PWM_HIGH) && state_ff.sync2[`CSW_IDX_PEAK] |=> !high_side_switch) // RULE14
    else $error("High side stayed on after peak overcurrent");
  a_soft_start_first: assert property ($rose(charge_active) |-> current_target == 16'(`CSW_SS_START_MA)) // RULE22
    else $error("Soft start did not begin low");

  c_high_pulse: cover property ($rose(high_side_switch) ##[1:400] $rose(low_side_switch));
  c_wd_expiry: cover property ($rose(watchdog_expired));
  c_inoc_latch: cover property ($rose(input_oc_latched));
  c_lowv_wait: cover property (state_ff.lowv == LOWV_LIMIT ##1 state_ff.lowv == LOWV_WAIT);

endmodule : csw_top

// >>> design/csw_consts.svh
`ifndef CSW_CONSTS_SVH
`define CSW_CONSTS_SVH

// Clock and tick prescaling
`define CSW_CLK_MHZ 40
`define CSW_CLK_NS 25
`define CSW_US_CYCLES (`CSW_CLK_MHZ * 1)
`define CSW_US_PER_MS 1000
`define CSW_MS_PER_S 1000

// Synchroniser bit positions
`define CSW_NUM_SYNC 11
`define CSW_IDX_PWM 0
`define CSW_IDX_EAO 1
`define CSW_IDX_BOOT 2
`define CSW_IDX_UCP 3
`define CSW_IDX_AVG_LO 4
`define CSW_IDX_AVG_HI 5
`define CSW_IDX_BATLOW 6
`define CSW_IDX_INOC 7
`define CSW_IDX_ADPLO 8
`define CSW_IDX_PEAK 9
`define CSW_IDX_OVP 10

// Option field positions
`define CSW_OPT_INHIBIT_BIT 0
`define CSW_OPT_INOC_EN_BIT 1
`define CSW_OPT_WD_LSB 13
`define CSW_OPT_WD_MSB 14

// Watchdog periods in seconds, selected by the option field
`define CSW_WD_SEL_OFF 2'h0
`define CSW_WD_SEL_44 2'h1
`define CSW_WD_SEL_88 2'h2
`define CSW_WD_SEL_175 2'h3
`define CSW_WD_44_S 44
`define CSW_WD_88_S 88
`define CSW_WD_175_S 175

// Fault timing
`define CSW_INOC_BLANK_US 4200
`define CSW_OVP_MS 30
`define CSW_LOWV_LIMIT_MS 1
`define CSW_LOWV_WAIT_MAX_MS 5
`define CSW_DEAD_NS 50
`define CSW_DEAD_CYCLES ((`CSW_DEAD_NS + `CSW_CLK_NS - 1) / `CSW_CLK_NS)

// Current targets in mA
`define CSW_SS_START_MA 128
`define CSW_SS_STEP_MA 64
`define CSW_SS_STEP_US 240
`define CSW_LOWV_CAP_MA 500
`define CSW_OCP_MID_FROM_MA 4096
`define CSW_OCP_HIGH_FROM_MA 6144
`define CSW_OCP_6A 2'h0
`define CSW_OCP_9A 2'h1
`define CSW_OCP_12A 2'h2

`endif

// >>> design/csw_pkg.sv
package csw_pkg;

  typedef enum logic [2:0] {
    PWM_IDLE = 3'h0,
    PWM_DEAD_H = 3'h1,
    PWM_HIGH = 3'h3,
    PWM_DEAD_L = 3'h2,
    PWM_LOW = 3'h6,
    PWM_OFF = 3'h7
  } csw_pwm_state_type;

  typedef enum logic [1:0] {
    LOWV_IDLE = 2'h0,
    LOWV_LIMIT = 2'h1,
    LOWV_WAIT = 2'h3
  } csw_lowv_state_type;

  typedef struct packed {
    logic [11:0] us_cnt;
    logic [11:0] ms_cnt;
    logic [11:0] s_cnt;
    logic us;
    logic ms;
    logic s;
  } csw_tick_state_type;

  typedef struct packed {
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic pwm_prev;
    csw_pwm_state_type pwm;
    logic [3:0] dead_cnt;
    logic refresh;
    logic [7:0] wd_cnt;
    logic wd_exp;
    logic [12:0] inoc_cnt;
    logic inoc_lat;
    logic [5:0] ovp_cnt;
    logic ovp_off;
    csw_lowv_state_type lowv;
    logic [11:0] lowv_cnt;
    logic nonsync;
    logic [7:0] ss_cnt;
    logic [15:0] target;
    logic chg;
    logic hs;
    logic ls;
    logic sink;
    logic adp;
    logic [1:0] ocp_lvl;
  } csw_state_type;

endpackage : csw_pkg

// >>> design/csw_tick_if.sv
`timescale 1ns/1ps
interface csw_tick_if;
  logic us_tick;
  logic ms_tick;
  logic s_tick;
  modport src (output us_tick, output ms_tick, output s_tick);
  modport dst (input us_tick, input ms_tick, input s_tick);
endinterface : csw_tick_if

// >>> design/csw_tick_gen.sv
`timescale 1ns/1ps
`include "csw_consts.svh"
// One-cycle tick pulses every microsecond, millisecond and second
module csw_tick_gen
  import csw_pkg::*;
#(
  parameter int US_CYCLES = `CSW_US_CYCLES,
  parameter int US_PER_MS = `CSW_US_PER_MS,
  parameter int MS_PER_S = `CSW_MS_PER_S
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  csw_tick_if.src tick
);

  csw_tick_state_type state_ff;
  csw_tick_state_type nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.us = 1'b0;
    nxt_state.ms = 1'b0;
    nxt_state.s = 1'b0;
    if (state_ff.us_cnt >= 12'(US_CYCLES - 1)) begin
      nxt_state.us_cnt = 12'h000;
      nxt_state.us = 1'b1;
    end else begin
      nxt_state.us_cnt = state_ff.us_cnt + 12'h001;
    end
    if (state_ff.us) begin
      if (state_ff.ms_cnt >= 12'(US_PER_MS - 1)) begin
        nxt_state.ms_cnt = 12'h000;
        nxt_state.ms = 1'b1;
      end else begin
        nxt_state.ms_cnt = state_ff.ms_cnt + 12'h001;
      end
    end
    if (state_ff.ms) begin
      if (state_ff.s_cnt >= 12'(MS_PER_S - 1)) begin
        nxt_state.s_cnt = 12'h000;
        nxt_state.s = 1'b1;
      end else begin
        nxt_state.s_cnt = state_ff.s_cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign tick.us_tick = state_ff.us;
  assign tick.ms_tick = state_ff.ms;
  assign tick.s_tick = state_ff.s;

endmodule : csw_tick_gen

// >>> testbench/csw_host_model.sv
`timescale 1ns/1ps
// Host side: programs limits and options with one-cycle write strobes
module csw_host_model (
  input wire logic sys_clk,
  output logic voltage_limit_write,
  output logic current_limit_write,
  output logic option_write,
  output logic [15:0] option_settings,
  output logic [15:0] voltage_limit,
  output logic [15:0] current_limit
);
  initial begin
    {voltage_limit_write, current_limit_write, option_write} = 3'h0;
    {option_settings, voltage_limit, current_limit} = 48'h0;
  end
  // Value and strobe rise on one edge; the strobe drops on the next
  task automatic wr(input int kind, input logic [15:0] val);
    @(posedge sys_clk);
    case (kind)
      0: begin
        voltage_limit <= val;
        voltage_limit_write <= 1'b1;
      end
      1: begin
        current_limit <= val;
        current_limit_write <= 1'b1;
      end
      default: begin
        option_settings <= val;
        option_write <= 1'b1;
      end
    endcase
    @(posedge sys_clk);
    {voltage_limit_write, current_limit_write, option_write} <= 3'h0;
  endtask : wr
endmodule : csw_host_model

// >>> testbench/charge_supervisor_watchdog_tb.sv
`timescale 1ns/1ps
module charge_supervisor_watchdog_tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, pwm_clk, error_amp_out = 1'b0, bootstrap_low = 1'b0;
  logic undercurrent_cmp = 1'b0, avg_below_125ma = 1'b0, avg_above_250ma = 1'b0, battery_low = 1'b0;
  logic input_overcurrent = 1'b0, adapter_detect_low = 1'b0, peak_overcurrent = 1'b0;
  logic battery_overvoltage = 1'b0, adapter_ready = 1'b1;
  logic voltage_limit_write, current_limit_write, option_write;
  logic [15:0] option_settings, voltage_limit, current_limit, current_target;
  logic high_side_switch, low_side_switch, adapter_switch, discharge_sink, charge_active;
  logic watchdog_expired, input_oc_latched, ovp_shutdown, nonsync_mode, hs_q, ls_q;
  logic [1:0] peak_ocp_level;
  logic [8:0] mon;
  int err_count = 0, check_count = 0;
  int wd_s[4] = '{0, 44, 88, 175};
  logic [15:0] row_cur[5] = '{16'h0064, 16'h0fff, 16'h1000, 16'h17ff, 16'h1800};
  logic [1:0] row_lvl[5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
  localparam int HS = 0, LS = 1, CA = 2, WD = 3, OC = 4, OV = 5, SK = 6, NS = 7, AS = 8;
  assign mon = {adapter_switch, nonsync_mode, discharge_sink, ovp_shutdown, input_oc_latched,
                watchdog_expired, charge_active, low_side_switch, high_side_switch};
  always #12.5 sys_clk = ~sys_clk;
  // Switching clock offset so its edges never coincide with the system clock
  initial begin
    pwm_clk = 1'b0;
    #37;
    forever #100 pwm_clk = ~pwm_clk;
  end
  csw_host_model host_u (.sys_clk, .voltage_limit_write, .current_limit_write, .option_write,
    .option_settings, .voltage_limit, .current_limit);
  csw_top #(.US_CYCLES(2), .US_PER_MS(4), .MS_PER_S(4), .INOC_BLANK_US(8), .DEAD_CYCLES(2)) dut_u (
    .sys_clk, .rst_n, .pwm_clk, .error_amp_out, .bootstrap_low, .undercurrent_cmp, .avg_below_125ma,
    .avg_above_250ma, .battery_low, .input_overcurrent, .adapter_detect_low, .peak_overcurrent,
    .battery_overvoltage, .voltage_limit_write, .current_limit_write, .option_write, .option_settings,
    .voltage_limit, .current_limit, .adapter_ready, .high_side_switch, .low_side_switch, .adapter_switch,
    .discharge_sink, .charge_active, .watchdog_expired, .input_oc_latched, .ovp_shutdown, .nonsync_mode,
    .peak_ocp_level, .current_target);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic waitc(input int sel, input logic v, input int n);
    int i;
    i = 0;
    while (mon[sel] !== v && i < n) begin
      @(negedge sys_clk);
      i++;
    end
    chk(16'(mon[sel]), 16'(v));
  endtask : waitc
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // Overlap or a direct hand-over without an idle cycle between gates
  always @(negedge sys_clk) begin
    if (rst_n && ((high_side_switch && (low_side_switch || ls_q)) || (hs_q && low_side_switch)))
      chk(16'h0001, 16'h0000);
    hs_q = high_side_switch;
    ls_q = low_side_switch;
  end
  initial begin
    #750000;
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    chk(16'(mon), 16'h0000);
    rst_n <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      host_u.wr(1, row_cur[k]);
      repeat (3) @(negedge sys_clk);
      chk(16'(peak_ocp_level), 16'(row_lvl[k]));
    end
    host_u.wr(0, 16'h3000);
    host_u.wr(1, 16'h0100);
    waitc(CA, 1'b1, 50);
    chk(current_target, 16'h0080);
    repeat (1500) @(negedge sys_clk);
    chk(current_target, 16'h0100);
    @(posedge sys_clk) error_amp_out <= 1'b1;
    waitc(HS, 1'b1, 40);
    @(posedge sys_clk) peak_overcurrent <= 1'b1;
    waitc(HS, 1'b0, 8);
    @(posedge sys_clk) peak_overcurrent <= 1'b0;
    waitc(HS, 1'b1, 24);
    @(posedge sys_clk) error_amp_out <= 1'b0;
    waitc(LS, 1'b1, 20);
    @(posedge sys_clk) undercurrent_cmp <= 1'b1;
    waitc(LS, 1'b0, 8);
    @(posedge sys_clk) avg_below_125ma <= 1'b1;
    waitc(NS, 1'b1, 10);
    repeat (12) @(negedge sys_clk);
    @(posedge sys_clk) undercurrent_cmp <= 1'b0;
    repeat (40) @(negedge sys_clk) chk(16'(low_side_switch), 16'h0000);
    @(posedge sys_clk) bootstrap_low <= 1'b1;
    waitc(LS, 1'b1, 24);
    @(posedge sys_clk) {bootstrap_low, avg_below_125ma, avg_above_250ma} <= 3'h1;
    waitc(NS, 1'b0, 10);
    @(posedge sys_clk) {avg_above_250ma, battery_overvoltage} <= 2'h1;
    waitc(SK, 1'b1, 8);
    waitc(HS, 1'b0, 4);
    repeat (4) @(negedge sys_clk) chk(16'(mon[LS:HS]), 16'h0000);
    repeat (190) @(negedge sys_clk);
    chk(16'(ovp_shutdown), 16'h0000);
    waitc(OV, 1'b1, 100);
    @(posedge sys_clk) battery_overvoltage <= 1'b0;
    waitc(SK, 1'b0, 8);
    host_u.wr(0, 16'h0000);
    @(posedge sys_clk) battery_overvoltage <= 1'b1;
    repeat (10) @(negedge sys_clk);
    chk(16'(mon[SK:OV]), 16'h0000);
    @(posedge sys_clk) battery_overvoltage <= 1'b0;
    host_u.wr(0, 16'h3000);
    host_u.wr(2, 16'h0002);
    @(posedge sys_clk) input_overcurrent <= 1'b1;
    repeat (10) @(negedge sys_clk);
    chk(16'(input_oc_latched), 16'h0000);
    waitc(OC, 1'b1, 40);
    waitc(AS, 1'b0, 4);
    @(posedge sys_clk) input_overcurrent <= 1'b0;
    repeat (8) @(negedge sys_clk);
    chk(16'(mon[AS:OC]), 16'h0001);
    @(posedge sys_clk) adapter_detect_low <= 1'b1;
    waitc(OC, 1'b0, 10);
    @(posedge sys_clk) adapter_detect_low <= 1'b0;
    waitc(AS, 1'b1, 10);
    host_u.wr(2, 16'h0000);
    @(posedge sys_clk) input_overcurrent <= 1'b1;
    repeat (60) @(negedge sys_clk);
    chk(16'(input_oc_latched), 16'h0000);
    @(posedge sys_clk) input_overcurrent <= 1'b0;
    waitc(CA, 1'b1, 20);
    host_u.wr(2, 16'h0001);
    waitc(CA, 1'b0, 10);
    host_u.wr(2, 16'h0000);
    waitc(CA, 1'b1, 10);
    @(posedge sys_clk) adapter_ready <= 1'b0;
    waitc(CA, 1'b0, 5);
    @(posedge sys_clk) adapter_ready <= 1'b1;
    waitc(CA, 1'b1, 5);
    @(posedge sys_clk) battery_low <= 1'b1;
    waitc(CA, 1'b0, 30);
    @(posedge sys_clk) battery_low <= 1'b0;
    repeat (20) @(negedge sys_clk) chk(16'(charge_active), 16'h0000);
    waitc(CA, 1'b1, 60);
    for (int f = 1; f < 4; f++) begin
      host_u.wr(2, 16'(f) << 13);
      host_u.wr(1, 16'h0100);
      repeat (wd_s[f] * 32 - 50) @(negedge sys_clk);
      chk(16'(watchdog_expired), 16'h0000);
      waitc(WD, 1'b1, 150);
      waitc(CA, 1'b0, 5);
      chk(16'(peak_ocp_level), 16'h0000);
      host_u.wr(f == 3 ? 2 : 1, f == 3 ? 16'h0000 : 16'h0100);
      waitc(WD, 1'b0, 5);
      waitc(CA, 1'b1, 20);
    end
    end_of_test();
  end
endmodule : charge_supervisor_watchdog_tb
